// *** six_bit_gpio_port.sv ***
// Purpose: APB register file and top of the six-pin port
// Assumes: APB3 slave, zero wait states
// Notes: unmapped addresses read zero and report pslverr
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"
// Operation
// - six pins, five bidirectional and one input-only, each with direction and configuration bits; all but input-only pin three have a latch bit.
// - direction bit one disables the pin's output driver.
// - direction bit zero drives the pin with its latch value.
// - pin three is input-only; its direction bit reads one.
// - latch register and port register writes both update the latch.
// - latch read returns latch; port read returns sampled pin levels.
// - port writes are read-modify-write into the latch.
// - analog-select set disables the pin's digital input buffer.
// - digital reads of analog-selected pins return zero.
// - analog-select does not affect digital output drive.
// - all implemented analog-select bits are set after reset.
// - open-drain set sinks only; clear drives push-pull.
// - slew bit set limits output slew rate.
// - threshold bit picks Schmitt or TTL input levels for reads.
// - peripheral-owned pin is not driven by latch but still readable.
// - pull-up disabled whenever pin is an output.
// - per-pin pull-ups act only while global disable is clear.
module six_bit_gpio_port (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`PIN_N-1:0] pin_in,
  input wire logic [`PIN_N-1:0] periph_out,
  output logic [`PIN_N-1:0] pin_out,
  output logic [`PIN_N-1:0] pin_oe_n,
  output logic [`PIN_N-1:0] pin_slew_limit,
  output logic [`PIN_N-1:0] pin_ttl_sel,
  output logic [`PIN_N-1:0] pin_pull_up_en,
  output logic [`PIN_N-1:0] port_level
);
  gpio_port_pkg::regs_s r_q;
  gpio_port_pkg::regs_s r_d;
  logic wr;
  logic rd;
  logic hit;
  gpio_port_pkg::pins_t wv;
  pin_ctrl_if ctl ();

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign wv = pwdata[`PIN_N-1:0];
  always_comb begin
    unique case (paddr)
      `PORT_OFS, `DIR_OFS, `LATCH_OFS, `ANALOG_OFS, `OPEN_DRAIN_OFS, `SLEW_OFS, `THRESH_OFS,
      `PULL_UP_OFS, `OPTION_OFS, `PERIPH_OFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    if (wr) begin
      unique case (paddr)
        // the written value replaces every latch bit but bit three; the read part of rmw
        // is the bus master's, so the stored result is the written word
        `PORT_OFS: r_d.latch = wv & `OPEN_DRAIN_IMPL;
        `LATCH_OFS: r_d.latch = wv & `OPEN_DRAIN_IMPL;
        `DIR_OFS: r_d.dir = wv | (6'h01 << `INPUT_ONLY_BIT);
        `ANALOG_OFS: r_d.analog = wv & `ANALOG_IMPL;
        `OPEN_DRAIN_OFS: r_d.open_drain = wv & `OPEN_DRAIN_IMPL;
        `SLEW_OFS: r_d.slew = wv & `OPEN_DRAIN_IMPL;
        `THRESH_OFS: r_d.thresh = wv;
        `PULL_UP_OFS: r_d.pull_up = wv;
        `OPTION_OFS: r_d.pull_up_off = pwdata[`PULL_UP_OFF_BIT];
        `PERIPH_OFS: r_d.periph = wv;
        default: r_d.rdata = r_q.rdata;
      endcase
    end
    if (rd) begin
      unique case (paddr)
        `PORT_OFS: r_d.rdata = {26'h0, ctl.level};
        `LATCH_OFS: r_d.rdata = {26'h0, r_q.latch};
        `DIR_OFS: r_d.rdata = {26'h0, r_q.dir};
        `ANALOG_OFS: r_d.rdata = {26'h0, r_q.analog};
        `OPEN_DRAIN_OFS: r_d.rdata = {26'h0, r_q.open_drain};
        `SLEW_OFS: r_d.rdata = {26'h0, r_q.slew};
        `THRESH_OFS: r_d.rdata = {26'h0, r_q.thresh};
        `PULL_UP_OFS: r_d.rdata = {26'h0, r_q.pull_up};
        `OPTION_OFS: r_d.rdata = {31'h0, r_q.pull_up_off};
        `PERIPH_OFS: r_d.rdata = {26'h0, r_q.periph};
        default: r_d.rdata = 32'h0;
      endcase
    end
    if (srst) begin
      r_d.dir = `DIR_RST;
      r_d.latch = `LATCH_RST;
      r_d.analog = `ANALOG_IMPL;
      r_d.open_drain = `OPEN_DRAIN_RST;
      r_d.slew = `SLEW_RST;
      r_d.thresh = `THRESH_RST;
      r_d.pull_up = `PULL_UP_RST;
      r_d.pull_up_off = `OPTION_RST;
      r_d.periph = `PERIPH_RST;
      r_d.rdata = 32'h0;
    end
  end
  always_ff @(posedge mclk) begin
    r_q <= r_d;
  end
  assign prdata = r_q.rdata;

  // ----------------------------------------
  // pad logic
  // ----------------------------------------
  assign ctl.dir = r_q.dir;
  assign ctl.latch = r_q.latch;
  assign ctl.analog = r_q.analog;
  assign ctl.open_drain = r_q.open_drain;
  assign ctl.slew = r_q.slew;
  assign ctl.thresh = r_q.thresh;
  assign ctl.pull_up = r_q.pull_up;
  assign ctl.pull_up_off = r_q.pull_up_off;
  assign ctl.periph = r_q.periph;
  assign port_level = ctl.level;

  pin_pads pads (
    .mclk(mclk),
    .srst(srst),
    .ctl(ctl),
    .pin_in(pin_in),
    .periph_out(periph_out),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_slew_limit(pin_slew_limit),
    .pin_ttl_sel(pin_ttl_sel),
    .pin_pull_up_en(pin_pull_up_en)
  );
endmodule

// *** gpio_port_cfg.svh ***
// Purpose: offsets, reset values and field widths of the six-pin port
// Assumes: APB byte addresses, one register per aligned word
// Notes: definitions only
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH
`define PORT_OFS 12'h000
`define DIR_OFS 12'h004
`define LATCH_OFS 12'h008
`define ANALOG_OFS 12'h00c
`define OPEN_DRAIN_OFS 12'h010
`define SLEW_OFS 12'h014
`define THRESH_OFS 12'h018
`define PULL_UP_OFS 12'h01c
`define OPTION_OFS 12'h020
`define PERIPH_OFS 12'h024
`define ADDR_W 12
`define PIN_N 6
`define INPUT_ONLY_BIT 3
`define DIR_RST 6'h3f
`define LATCH_RST 6'h00
`define ANALOG_IMPL 6'h17
`define OPEN_DRAIN_IMPL 6'h37
`define OPEN_DRAIN_RST 6'h00
`define SLEW_RST 6'h37
`define THRESH_RST 6'h00
`define PULL_UP_RST 6'h3f
`define OPTION_RST 1'h1
`define PULL_UP_OFF_BIT 0
`define PERIPH_RST 6'h00
`endif

// *** gpio_port_pkg.sv ***
// Purpose: shared types of the six-pin port
// Assumes: gpio_port_cfg.svh holds the numbers
// Notes: none
`include "gpio_port_cfg.svh"
package gpio_port_pkg;
  typedef logic [`PIN_N-1:0] pins_t;
  typedef struct packed {
    pins_t dir;
    pins_t latch;
    pins_t analog;
    pins_t open_drain;
    pins_t slew;
    pins_t thresh;
    pins_t pull_up;
    logic pull_up_off;
    pins_t periph;
    logic [31:0] rdata;
  } regs_s;
endpackage

// *** pin_ctrl_if.sv ***
// Purpose: per-pin control bundle from register file to pad logic
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
interface pin_ctrl_if;
  gpio_port_pkg::pins_t dir;
  gpio_port_pkg::pins_t latch;
  gpio_port_pkg::pins_t analog;
  gpio_port_pkg::pins_t open_drain;
  gpio_port_pkg::pins_t slew;
  gpio_port_pkg::pins_t thresh;
  gpio_port_pkg::pins_t pull_up;
  logic pull_up_off;
  gpio_port_pkg::pins_t periph;
  gpio_port_pkg::pins_t level;
  modport ctrl (output dir, output latch, output analog, output open_drain, output slew,
    output thresh, output pull_up, output pull_up_off, output periph, input level);
  modport pads (input dir, input latch, input analog, input open_drain, input slew,
    input thresh, input pull_up, input pull_up_off, input periph, output level);
endinterface

// *** pin_pads.sv ***
// Purpose: pad-side drive and sense of the six pins
// Assumes: pad cells take enables, slew and threshold selects
// Notes: output enables are active low
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"
module pin_pads (
  input wire logic mclk,
  input wire logic srst,
  pin_ctrl_if.pads ctl,
  input wire logic [`PIN_N-1:0] pin_in,
  input wire logic [`PIN_N-1:0] periph_out,
  output logic [`PIN_N-1:0] pin_out,
  output logic [`PIN_N-1:0] pin_oe_n,
  output logic [`PIN_N-1:0] pin_slew_limit,
  output logic [`PIN_N-1:0] pin_ttl_sel,
  output logic [`PIN_N-1:0] pin_pull_up_en
);
  typedef struct packed {
    gpio_port_pkg::pins_t out;
    gpio_port_pkg::pins_t oe_n;
    gpio_port_pkg::pins_t slew;
    gpio_port_pkg::pins_t ttl;
    gpio_port_pkg::pins_t pull;
    gpio_port_pkg::pins_t level;
  } pad_s;
  pad_s s_q;
  pad_s s_d;
  gpio_port_pkg::pins_t src;
  gpio_port_pkg::pins_t gpio_dir;
  // ----------------------------------------
  // pad control
  // ----------------------------------------
  always_comb begin
    src = (ctl.periph & periph_out) | (~ctl.periph & ctl.latch);
    gpio_dir = ctl.dir;
    gpio_dir[`INPUT_ONLY_BIT] = 1'b1;
    s_d = s_q;
    s_d.out = src;
    // open drain drives low only; high releases the pin
    s_d.oe_n = gpio_dir | (ctl.open_drain & src);
    s_d.slew = ctl.slew;
    s_d.ttl = ctl.thresh;
    s_d.pull = ctl.pull_up & gpio_dir & {`PIN_N{~ctl.pull_up_off}};
    s_d.level = pin_in & ~ctl.analog;
    if (srst) begin
      s_d.out = '0;
      s_d.oe_n = '1;
      s_d.slew = `SLEW_RST;
      s_d.ttl = `THRESH_RST;
      s_d.pull = '0;
      s_d.level = '0;
    end
  end
  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end
  assign pin_out = s_q.out;
  assign pin_oe_n = s_q.oe_n;
  assign pin_slew_limit = s_q.slew;
  assign pin_ttl_sel = s_q.ttl;
  assign pin_pull_up_en = s_q.pull;
  assign ctl.level = s_q.level;
endmodule

// *** gpio_port_sva.sv ***
// Purpose: port-level checks of the six-pin port
// Assumes: zero-wait APB, pads follow a write two edges later
// Notes: bound to the top module
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"
module gpio_port_sva (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [`PIN_N-1:0] pin_oe_n,
  input wire logic [`PIN_N-1:0] pin_slew_limit,
  input wire logic [`PIN_N-1:0] pin_ttl_sel,
  input wire logic [`PIN_N-1:0] pin_pull_up_en
);
  // ----------
  // assertions
  // ----------
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & !pwrite;
  wire [5:0] wd = pwdata[5:0];
  chk_ready_high: assert property (acc |-> pready)
    else $error("pready low in access");
  chk_dir_release: assert property (wr && paddr == `DIR_OFS |-> ##2 (pin_oe_n & $past(wd, 2)) == $past(wd, 2))
    else $error("input pin still driven");
  chk_input_only: assert property (pin_oe_n[3])
    else $error("input-only pin driven");
  chk_pull_output: assert property ((pin_pull_up_en & ~pin_oe_n) == 6'h00)
    else $error("pull-up on driven pin");
  chk_slew_write: assert property (wr && paddr == `SLEW_OFS |-> ##2 pin_slew_limit == ($past(wd, 2) & 6'h37))
    else $error("slew select wrong");
  chk_thresh_write: assert property (wr && paddr == `THRESH_OFS |-> ##2 pin_ttl_sel == $past(wd, 2))
    else $error("threshold select wrong");
  chk_global_pull: assert property (wr && paddr == `OPTION_OFS && pwdata[0] |-> ##2 pin_pull_up_en == 6'h00)
    else $error("pull-up with global off");
  chk_unmapped_err: assert property (acc && paddr > `PERIPH_OFS |-> pslverr)
    else $error("no error on unmapped");
  chk_read_upper: assert property (rd |-> prdata[31:6] == 26'h0)
    else $error("upper read bits set");
  chk_dir_bit3: assert property (rd && paddr == `DIR_OFS |-> prdata[3])
    else $error("dir bit three reads zero");
  cover property (wr && paddr == `DIR_OFS);
  cover property (acc && pslverr);
  cover property (rd && paddr == `PORT_OFS);
endmodule
bind six_bit_gpio_port gpio_port_sva SVA (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_oe_n(pin_oe_n), .pin_slew_limit(pin_slew_limit), .pin_ttl_sel(pin_ttl_sel),
  .pin_pull_up_en(pin_pull_up_en));

// *** pad_board.sv ***
// Purpose: board circuitry on the six pins
// Assumes: ext_drv marks pins held by a board driver
// Notes: a released pin without board driver or pull-up shows the inverse of its drive value
`timescale 1ns/1ps
module pad_board (
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic [5:0] pin_pull_up_en,
  input wire logic [5:0] ext_drv,
  input wire logic [5:0] ext_val,
  output logic [5:0] pin_in
);
  // -----------
  // pin levels
  // -----------
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_drv[i]) pin_in[i] = ext_val[i];
      else if (pin_pull_up_en[i]) pin_in[i] = 1'h1;
      else pin_in[i] = ~pin_out[i];
    end
  end
endmodule

// *** six_bit_gpio_port_tb_top.sv ***
// Purpose: self-checking bench of the six-pin port
// Assumes: pad_board on the pins
// Notes: apb waits for pready under the watchdog
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"
module six_bit_gpio_port_tb_top;
  // -------
  // bench
  // -------
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [5:0] periph_out = 6'h0;
  logic [5:0] ext_drv = 6'h3f;
  logic [5:0] ext_val = 6'h3f;
  logic [5:0] pin_in, pin_out, pin_oe_n, slew, ttl, pull, lvl;
  int bad_count = 0;
  int tests_run = 0;
  always #25 mclk = ~mclk;
  six_bit_gpio_port DUT (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .periph_out(periph_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_slew_limit(slew),
    .pin_ttl_sel(ttl), .pin_pull_up_en(pull), .port_level(lvl));
  pad_board BRD (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up_en(pull),
    .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));
  task automatic chk(input string n, input logic [5:0] s, input logic [5:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [5:0] d);
    apb(1'h1, a, {26'h0, d});
  endtask
  task automatic rc(input string n, input logic [11:0] a, input logic [5:0] e);
    apb(1'h0, a, 32'h0);
    chk(n, rd[5:0], e);
  endtask
  task automatic t_reset;
    logic [5:0] e [9] = '{6'h3f, 6'h00, 6'h17, 6'h00, 6'h37, 6'h00, 6'h3f, 6'h01, 6'h00};
    for (int i = 0; i < 9; i++) rc("reset value", 12'(4 * i + 4), e[i]);
    chk("oe at reset", pin_oe_n, 6'h3f);
    rc("analog port", `PORT_OFS, 6'h28);
    wr(12'h028, 6'h3f);
    rc("unmapped", 12'h028, 6'h00);
    chk("unmapped err", {5'h0, err}, 6'h01);
  endtask
  task automatic t_drive;
    wr(`ANALOG_OFS, 6'h00);
    wr(`DIR_OFS, 6'h00);
    wr(`LATCH_OFS, 6'h2a);
    ext_drv <= 6'h08;
    repeat (4) @(negedge mclk);
    chk("oe out", pin_oe_n, 6'h08);
    chk("drive", pin_out, 6'h22);
    rc("dir read", `DIR_OFS, 6'h08);
    rc("latch read", `LATCH_OFS, 6'h22);
    rc("port read", `PORT_OFS, 6'h2a);
    wr(`PORT_OFS, 6'h15);
    repeat (2) @(negedge mclk);
    chk("port write", pin_out, 6'h15);
    rc("latch after port", `LATCH_OFS, 6'h15);
  endtask
  task automatic t_analog;
    wr(`ANALOG_OFS, 6'h01);
    repeat (4) @(negedge mclk);
    chk("analog drive", pin_oe_n, 6'h08);
    chk("level out", lvl, 6'h1c);
    rc("analog read", `PORT_OFS, 6'h1c);
    wr(`ANALOG_OFS, 6'h00);
  endtask
  task automatic t_od;
    wr(`OPEN_DRAIN_OFS, 6'h01);
    repeat (2) @(negedge mclk);
    chk("od release", pin_oe_n, 6'h09);
    rc("od level", `PORT_OFS, 6'h1c);
    wr(`LATCH_OFS, 6'h14);
    repeat (2) @(negedge mclk);
    chk("od sink", pin_oe_n, 6'h08);
    wr(`OPEN_DRAIN_OFS, 6'h00);
  endtask
  task automatic t_pull;
    wr(`OPTION_OFS, 6'h00);
    repeat (2) @(negedge mclk);
    chk("pull out", pull, 6'h08);
    wr(`DIR_OFS, 6'h3f);
    repeat (2) @(negedge mclk);
    chk("pull in", pull, 6'h3f);
    rc("pull level", `PORT_OFS, 6'h3f);
    wr(`OPTION_OFS, 6'h01);
    repeat (2) @(negedge mclk);
    chk("pull global", pull, 6'h00);
  endtask
  task automatic t_pads;
    wr(`SLEW_OFS, 6'h00);
    wr(`THRESH_OFS, 6'h2a);
    repeat (2) @(negedge mclk);
    chk("slew", slew, 6'h00);
    chk("thresh", ttl, 6'h2a);
    wr(`DIR_OFS, 6'h00);
    wr(`LATCH_OFS, 6'h00);
    @(posedge mclk);
    periph_out <= 6'h01;
    wr(`PERIPH_OFS, 6'h01);
    repeat (4) @(negedge mclk);
    chk("periph drive", pin_out, 6'h01);
    rc("periph read", `PORT_OFS, 6'h09);
  endtask
  task automatic t_rerst;
    @(posedge mclk);
    srst <= 1'h1;
    repeat (2) @(posedge mclk);
    srst <= 1'h0;
    rc("analog rereset", `ANALOG_OFS, 6'h17);
    chk("oe rereset", pin_oe_n, 6'h3f);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'h0;
    t_reset;
    t_drive;
    t_analog;
    t_od;
    t_pull;
    t_pads;
    t_rerst;
    finish_test;
  end
endmodule
